/* src/lcd_cmd_interp.sv */
// Text command interpreter of a digital load cell: diagnostics, access-code guarded
// calibration, weight scaling, range handling and zero tracking.
// Assumes an APB master feeding command characters and samples on the same clock.
// Behaviour
// - Type query replies D: followed by a fixed four-digit device code.
// - Version query replies V: followed by a fixed four-digit firmware code.
// - Status query replies S: then a three-digit decimal flag sum and a fixed 000.
// - Left value: 1 stable, 2 zero done, 4 tare; all else zero.
// - Reset command answers OK, then resets itself within 400 ms.
// - Unlock without parameter replies E, sign, five-digit access code.
// - Protected write without valid unlock answers ERR, stores nothing.
// - Three maximum limits 1 to 999999; defaults 999999, 0, 0; queryable.
// - Above present maximum, output shows over-range zero or moves to next range.
// - Minimum limit -999999 to 0, default -9; below flags under-range.
// - Range mode 0 multi interval, 1 multi range, default 0, queryable.
// - Step only from 1,2,5,10,20,50,100,200,500; default 1; output quantised.
// - Higher ranges use the next larger allowed step.
// - Decimal point position 0 to 6, default 3.
// - Unlocked zero calibration captures present signal as zero, answers OK.
// - Span calibration scales gain to hit target 1..9999999; query returns it.
// - Span calibration fails with ERR below 1 percent of full scale.
// - Zero tracking under half band, 0.4 steps per second, within zero range.
// - Tracking band defaults to zero; zero disables tracking.
// - Unlocked defaults command restores factory values, saves, bumps access code.
// - Unlocked save command stores calibration and bumps access code.
// - Zero range limit of zero means two percent of maximum capacity.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module lcd_cmd_interp
   import lcd_pkg::*;
#(
   parameter int RST_CYC = RST_DELAY_CYC,
   parameter int TRK_CYC = TRK_STEP_CYC,
   parameter int FS_COUNTS = FS_COUNTS_DEF,
   // Arbitrary four-digit BCD identity values
   parameter logic [15:0] DEV_CODE = 16'h0000,
   parameter logic [15:0] FW_CODE = 16'h0000
)(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire lcd_smp_s i_smp,
   output lcd_res_s o_res,
   output logic o_nvm_save,
   output logic o_sys_reset
);
   localparam logic [24:0] MIN_LOAD = 25'(FS_COUNTS * MIN_LOAD_PCT / 100);
   localparam logic [31:0] RST_END = 32'(RST_CYC - 1);
   localparam logic [31:0] TRK_END = 32'(TRK_CYC - 1);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic lcd_state_s cal_dflt(input lcd_state_s s);
      s.mx = {24'h0, 24'h0, MAX_VAL};
      s.mnl = MINL_DEF;
      s.rmode = 1'b0;
      s.dsi = 4'h0;
      s.point = POINT_DEF;
      s.zero = 24'h0;
      s.gain = GAIN_DEF;
      s.cgw = 24'h0;
      s.ztb = 24'h0;
      s.zrl = 24'h0;
      return s;
   endfunction

   function automatic logic [31:0] bcd(input logic [23:0] b);
      logic [55:0] s;
      s = {32'h0, b};
      for (int i = 0; i < 24; i++) begin
         for (int j = 0; j < 8; j++) begin
            if (s[24+4*j +: 4] > 4'h4) begin
               s[24+4*j +: 4] = s[24+4*j +: 4] + 4'h3;
            end
         end
         s = {s[54:0], 1'b0};
      end
      return s[55:24];
   endfunction

   function automatic logic [7:0][7:0] place(input logic [7:0][7:0] b, input int pos,
                                             input int n, input logic [31:0] bd);
      for (int i = 0; i < 8; i++) begin
         if (i >= pos && i < pos + n) begin
            b[i] = {CH_DIG_HI, bd[4*(pos+n-1-i) +: 4]};
         end
      end
      return b;
   endfunction

   function automatic lcd_state_s fin(input lcd_state_s s);
      if (s.ind) begin
         s.ind = 1'b0;
         s.nd = 3'h0;
         s.nc = s.nc + 2'h1;
      end
      return s;
   endfunction

   localparam lcd_state_s RST_S = cal_dflt(lcd_state_s'('0));

   lcd_state_s q, d;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [7:0] c;
      logic [3:0] dg, si;
      logic [24:0] net, raw, cv, acv;
      logic signed [57:0] prod;
      logic [1:0] r, ix;
      logic [9:0] stp;
      logic [24:0] t;
      logic [47:0] nq;
      logic [23:0] nr, mv;
      logic [34:0] m;
      logic [33:0] band, lim;
      logic [31:0] nt, at;
      logic er, ok, nm, nn, em, rxr, acc, nok;
      logic [23:0] nmag, v0, v1;
      logic [7:0][7:0] b;
      logic [3:0] bl;
      d = q;
      c = i_pwdata[7:0];
      dg = c[3:0];
      si = 4'h0;
      r = 2'h0;
      t = 25'h0;
      nq = 48'h0;
      nr = 24'h0;
      mv = 24'h0;
      m = 35'h0;
      nt = 32'h0;
      at = 32'h0;
      er = 1'b1;
      ok = 1'b0;
      nm = 1'b0;
      nn = 1'b0;
      em = 1'b0;
      nmag = 24'h0;
      b = 64'h0;
      bl = 4'h0;
      net = 25'h0;
      raw = 25'h0;
      cv = 25'h0;
      acv = 25'h0;
      prod = 58'h0;
      stp = 10'h0;
      band = 34'h0;
      lim = 34'h0;
      v0 = q.nv[0];
      v1 = q.nv[1];
      ix = 2'(v0[1:0] - 2'h1);
      nok = !q.ng[0] && v0 != 24'h0 && v0 < 24'h4;
      d.srst = 1'b0;
      d.nvm = 1'b0;
      acc = i_psel && i_penable;
      rxr = q.st == ST_IDLE && q.rp == q.rl && !q.sra;

      // ****************************************
      // Register bus
      // ****************************************
      if (i_psel && !i_penable) begin
         unique case (i_paddr)
            A_TX: d.prd = {23'h0, q.rp != q.rl, q.rb[q.rp[2:0]]};
            A_STAT: d.prd = {28'h0, q.db, q.unl, q.rp != q.rl, rxr};
            A_RES: d.prd = {q.res, 1'b0};
            default: d.prd = 32'h0;
         endcase
      end
      if (acc && !i_pwrite && i_paddr == A_TX && q.rp != q.rl) begin
         d.rp = q.rp + 4'h1;
      end

      // ****************************************
      // Character parser
      // ****************************************
      if (acc && i_pwrite && i_paddr == A_RX && rxr) begin
         if (c == CH_CR) begin
            d = fin(d);
            d.st = ST_EXEC;
         end else if ((c >= "A" && c <= "Z") || (c >= "a" && c <= "z")) begin
            if (q.lc == 2'h2 || q.ind || q.nc != 2'h0) begin
               d.perr = 1'b1;
            end else if (q.lc == 2'h0) begin
               d.l0 = c & 8'hDF;
            end else begin
               d.l1 = c & 8'hDF;
            end
            d.lc = q.lc + 2'h1;
         end else if (c >= "0" && c <= "9") begin
            if (q.nc == 2'h2 || q.nd == 3'h7) begin
               d.perr = 1'b1;
            end else begin
               d.nv[q.nc[0]] = q.ind ? 24'(q.nv[q.nc[0]] * 24'hA + {20'h0, dg}) : {20'h0, dg};
               d.ind = 1'b1;
               d.nd = q.nd + 3'h1;
            end
         end else if (c == "+" || c == "-") begin
            d = fin(d);
            if (d.nc != 2'h2) begin
               d.ng[d.nc[0]] = c == "-";
            end
         end else if (c == " " || c == "_" || c == ",") begin
            d = fin(d);
         end else begin
            d.perr = 1'b1;
         end
      end

      // ****************************************
      // Weight path
      // ****************************************
      net = 25'($signed({i_smp.value[23], i_smp.value}) - $signed({q.zero[23], q.zero}));
      prod = $signed(net) * $signed({1'b0, q.gain});
      raw = prod[40:16];
      cv = raw - {q.trk[31], q.trk[31:8]};
      acv = cv[24] ? -cv : cv;
      if ($signed(cv) > $signed({1'b0, q.mx[0]}) && q.mx[1] != 24'h0) begin
         r = 2'h1;
         if ($signed(cv) > $signed({1'b0, q.mx[1]}) && q.mx[2] != 24'h0) begin
            r = 2'h2;
         end
      end
      // Multi range keeps the higher range until the load returns to zero
      if (q.rmode && q.rng > r && !cv[24] && cv != 25'h0) begin
         r = q.rng;
      end
      si = (q.dsi + {2'h0, r} > STEP_LAST) ? STEP_LAST : q.dsi + {2'h0, r};
      stp = STEP_TAB[si];
      if (i_smp.valid && !q.db && q.st != ST_DIV) begin
         d.cv = cv;
         d.rng = r;
         d.stp = stp;
         d.ovr = $signed(cv) > $signed({1'b0, q.mx[r]});
         d.und = $signed(cv) < $signed({q.mnl[23], q.mnl});
         d.quo = {23'h0, acv};
         d.rem = 24'h0;
         d.den = {14'h0, stp};
         d.dneg = cv[24];
         d.dc = 6'h0;
         d.db = 1'b1;
      end

      // ****************************************
      // Shared divider: step quantisation and span
      // ****************************************
      if (q.db) begin
         t = {q.rem, q.quo[47]};
         nq = {q.quo[46:0], t >= {1'b0, q.den}};
         nr = t >= {1'b0, q.den} ? 24'(t - {1'b0, q.den}) : t[23:0];
         d.quo = nq;
         d.rem = nr;
         d.dc = q.dc + 6'h1;
         if (q.dc == DIV_LAST) begin
            d.db = 1'b0;
            if (q.dcal) begin
               d.dcal = 1'b0;
               d.st = ST_IDLE;
               em = 1'b1;
               if (nq[47:32] == 16'h0) begin
                  d.gain = nq[31:0];
                  d.cgw = v0;
                  er = 1'b0;
                  ok = 1'b1;
               end
            end else begin
               m = nq[24:0] * q.stp;
               mv = m[23:0];
               d.res.value = q.ovr ? 24'h0 : (q.dneg ? -mv : mv);
               d.res.over = q.ovr;
               d.res.under = q.und;
               d.res.range = q.rng;
            end
         end
      end
      d.res.point = q.point;

      // ****************************************
      // Command execution
      // ****************************************
      if (q.st == ST_DIV && !q.db) begin
         if (!net[24] && net >= MIN_LOAD) begin
            d.quo = {8'h0, v0, 16'h0};
            d.rem = 24'h0;
            d.den = net[23:0];
            d.dc = 6'h0;
            d.db = 1'b1;
            d.dcal = 1'b1;
         end else begin
            d.st = ST_IDLE;
            em = 1'b1;
         end
      end
      if (q.st == ST_EXEC) begin
         d.st = ST_IDLE;
         em = 1'b1;
         d.lc = 2'h0;
         d.nc = 2'h0;
         d.ng = 2'h0;
         d.perr = 1'b0;
         if (!q.perr && q.lc == 2'h2) begin
            unique case ({q.l0, q.l1})
               CMD_TYPE_Q: if (q.nc == 2'h0) begin
                  b = place({48'h0, ":", "D"}, 2, 4, {16'h0, DEV_CODE});
                  bl = 4'h6;
                  er = 1'b0;
               end
               CMD_VER_Q: if (q.nc == 2'h0) begin
                  b = place({48'h0, ":", "V"}, 2, 4, {16'h0, FW_CODE});
                  bl = 4'h6;
                  er = 1'b0;
               end
               CMD_STAT_Q: if (q.nc == 2'h0) begin
                  b = place({"000", 24'h0, ":", "S"}, 2, 3,
                            bcd({21'h0, i_smp.tare, q.zdone, i_smp.stable}));
                  bl = 4'h8;
                  er = 1'b0;
               end
               CMD_SWRST: if (q.nc == 2'h0) begin
                  d.sra = 1'b1;
                  d.src = 32'h0;
                  er = 1'b0;
                  ok = 1'b1;
               end
               CMD_UNLOCK: if (q.nc == 2'h0) begin
                  b = place({40'h0, "+", "E"}, 2, 5, bcd({8'h0, q.acode}));
                  bl = 4'h7;
                  er = 1'b0;
               end else if (q.nc == 2'h1) begin
                  d.unl = !q.ng[0] && v0 == {8'h0, q.acode};
                  er = !d.unl;
                  ok = d.unl;
               end
               CMD_MAXLIM: if (q.nc == 2'h0 || (q.nc == 2'h1 && nok)) begin
                  nm = 1'b1;
                  nmag = q.mx[q.nc == 2'h0 ? 2'h0 : ix];
               end else if (q.unl && nok && !q.ng[1] && v1 != 24'h0 && v1 <= MAX_VAL) begin
                  d.mx[ix] = v1;
                  ok = 1'b1;
               end
               CMD_MINLIM: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nn = q.mnl[23];
                  nmag = -q.mnl;
               end else if (q.unl && (q.ng[0] || v0 == 24'h0) && v0 <= MAX_VAL) begin
                  d.mnl = -v0;
                  ok = 1'b1;
               end
               CMD_RMODE: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nmag = {23'h0, q.rmode};
               end else if (q.unl && !q.ng[0] && v0 < 24'h2) begin
                  d.rmode = v0[0];
                  ok = 1'b1;
               end
               CMD_STEP: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nmag = {14'h0, STEP_TAB[q.dsi]};
               end else if (q.unl && !q.ng[0]) begin
                  for (int i = 0; i < 9; i++) begin
                     if (v0 == {14'h0, STEP_TAB[i]}) begin
                        d.dsi = 4'(i);
                        ok = 1'b1;
                     end
                  end
               end
               CMD_DPOS: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nmag = {21'h0, q.point};
               end else if (q.unl && !q.ng[0] && v0 <= {21'h0, POINT_MAX}) begin
                  d.point = v0[2:0];
                  ok = 1'b1;
               end
               CMD_ZCAL: if (q.nc == 2'h0 && q.unl && i_smp.stable) begin
                  d.zero = i_smp.value;
                  d.zdone = 1'b1;
                  ok = 1'b1;
               end
               CMD_SPAN: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nmag = q.cgw;
               end else if (q.unl && i_smp.stable && !q.ng[0] && v0 != 24'h0
                            && v0 <= CAL_MAX) begin
                  d.st = ST_DIV;
                  em = 1'b0;
               end
               CMD_ZTRK: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nmag = q.ztb;
               end else if (q.unl && !q.ng[0] && v0 <= MAX_VAL) begin
                  d.ztb = v0;
                  ok = 1'b1;
               end
               CMD_ZRNG: if (q.nc == 2'h0) begin
                  nm = 1'b1;
                  nmag = q.zrl;
               end else if (q.unl && !q.ng[0] && v0 <= MAX_VAL) begin
                  d.zrl = v0;
                  ok = 1'b1;
               end
               CMD_DEFLT: if (q.nc == 2'h0 && q.unl) begin
                  d = cal_dflt(d);
                  d.nvm = 1'b1;
                  d.acode = q.acode + 16'h1;
                  d.unl = 1'b0;
                  ok = 1'b1;
               end
               CMD_SAVE: if (q.nc == 2'h0 && q.unl) begin
                  d.nvm = 1'b1;
                  d.acode = q.acode + 16'h1;
                  d.unl = 1'b0;
                  ok = 1'b1;
               end
               default: ;
            endcase
            er = er && !ok && !nm;
         end
      end
      if (em) begin
         if (er) begin
            b = {40'h0, "RRE"};
            bl = 4'h3;
         end else if (ok) begin
            b = {48'h0, "KO"};
            bl = 4'h2;
         end else if (nm) begin
            b = place({56'h0, nn ? "-" : "+"}, 1, 7, bcd(nmag));
            bl = 4'h8;
         end
         d.rb = b;
         d.rl = bl;
         d.rp = 4'h0;
      end

      // ****************************************
      // Zero tracking
      // ****************************************
      d.tkc = q.tkc == TRK_END ? 32'h0 : q.tkc + 32'h1;
      band = {10'h0, q.ztb} * {24'h0, q.stp};
      lim = q.zrl == 24'h0 ? {10'h0, q.mx[0] / ZRNG_STD_DIV} : {10'h0, q.zrl} * {24'h0, q.stp};
      nt = q.cv[24] ? q.trk - {22'h0, q.stp} : q.trk + {22'h0, q.stp};
      at = nt[31] ? -nt : nt;
      if (q.tkc == TRK_END && q.ztb != 24'h0 && q.cv != 25'h0
          && {8'h0, (q.cv[24] ? -q.cv : q.cv), 1'b0} < band
          && {10'h0, at} <= {lim, 8'h0}) begin
         d.trk = nt;
      end

      // ****************************************
      // Software reset
      // ****************************************
      if (q.sra) begin
         d.src = q.src + 32'h1;
         // Fires once the OK has been read, or at the deadline if nobody reads it
         if (q.rp == q.rl || q.src == RST_END) begin
            d.srst = 1'b1;
            d.sra = 1'b0;
            d.st = ST_IDLE;
            d.lc = 2'h0;
            d.nc = 2'h0;
            d.ind = 1'b0;
            d.nd = 3'h0;
            d.perr = 1'b0;
            d.unl = 1'b0;
            d.zdone = 1'b0;
            d.trk = 32'h0;
            d.rl = 4'h0;
            d.rp = 4'h0;
            d.db = 1'b0;
            d.dcal = 1'b0;
         end
      end
   end

   // ****************************************
   // State register and outputs
   // ****************************************
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= RST_S;
      end else begin
         q <= d;
      end
   end

   assign o_prdata = q.prd;
   assign o_pready = i_psel && i_penable;
   assign o_pslverr = o_pready && !(i_paddr == A_RX || (!i_pwrite && (i_paddr == A_TX
                      || i_paddr == A_STAT || i_paddr == A_RES)));
   assign o_res = q.res;
   assign o_nvm_save = q.nvm;
   assign o_sys_reset = q.srst;
endmodule

/* src/lcd_pkg.sv */
// Shared constants, types and state record of the load cell command interpreter.
// Assumes a 125 MHz clock and an APB master that writes command characters one by one.
package lcd_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 8;
   localparam int RST_DELAY_MS = 400;
   localparam int RST_DELAY_CYC = RST_DELAY_MS * 1000000 / CLK_NS;
   // 1/256 display step at 0.4 steps per second
   localparam int TRK_STEP_NS = 9765625;
   localparam int TRK_STEP_CYC = TRK_STEP_NS / CLK_NS;
   localparam int FS_COUNTS_DEF = 512000;
   localparam int MIN_LOAD_PCT = 1;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] A_RX = 8'h00;
   localparam logic [7:0] A_TX = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_RES = 8'h0C;
   // ****************************************
   // Value limits and factory values
   // ****************************************
   localparam logic [23:0] MAX_VAL = 24'h0F423F;
   localparam logic [23:0] CAL_MAX = 24'h98967F;
   localparam logic [23:0] MINL_DEF = 24'hFFFFF7;
   localparam logic [23:0] ZRNG_STD_DIV = 24'h000032;
   localparam logic [2:0] POINT_DEF = 3'h3;
   localparam logic [2:0] POINT_MAX = 3'h6;
   localparam logic [31:0] GAIN_DEF = 32'h0001_0000;
   localparam logic [3:0] STEP_LAST = 4'h8;
   localparam logic [8:0][9:0] STEP_TAB = {10'h1F4, 10'h0C8, 10'h064, 10'h032, 10'h014,
                                            10'h00A, 10'h005, 10'h002, 10'h001};
   localparam logic [5:0] DIV_LAST = 6'h2F;
   localparam logic [3:0] CH_DIG_HI = 4'h3;
   localparam logic [7:0] CH_CR = 8'h0D;
   // ****************************************
   // Command codes (two upper-case letters)
   // ****************************************
   localparam logic [15:0] CMD_TYPE_Q = 16'h4944;
   localparam logic [15:0] CMD_VER_Q = 16'h4956;
   localparam logic [15:0] CMD_STAT_Q = 16'h4953;
   localparam logic [15:0] CMD_SWRST = 16'h5352;
   localparam logic [15:0] CMD_UNLOCK = 16'h4345;
   localparam logic [15:0] CMD_MAXLIM = 16'h434D;
   localparam logic [15:0] CMD_MINLIM = 16'h4349;
   localparam logic [15:0] CMD_RMODE = 16'h4D52;
   localparam logic [15:0] CMD_STEP = 16'h4453;
   localparam logic [15:0] CMD_DPOS = 16'h4450;
   localparam logic [15:0] CMD_ZCAL = 16'h435A;
   localparam logic [15:0] CMD_SPAN = 16'h4347;
   localparam logic [15:0] CMD_ZTRK = 16'h5A54;
   localparam logic [15:0] CMD_ZRNG = 16'h5A52;
   localparam logic [15:0] CMD_DEFLT = 16'h4644;
   localparam logic [15:0] CMD_SAVE = 16'h4353;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DIV = 2'b10} lcd_st_e;

   typedef struct packed {
      logic valid;
      logic stable;
      logic tare;
      logic [23:0] value;
   } lcd_smp_s;

   typedef struct packed {
      logic [23:0] value;
      logic over;
      logic under;
      logic [1:0] range;
      logic [2:0] point;
   } lcd_res_s;

   typedef struct packed {
      lcd_st_e st;
      logic [7:0] l0, l1;
      logic [1:0] lc, nc, ng;
      logic [1:0][23:0] nv;
      logic ind, perr;
      logic [2:0] nd;
      logic unl;
      logic [15:0] acode;
      logic [2:0][23:0] mx;
      logic [23:0] mnl, zero, cgw, ztb, zrl;
      logic rmode, zdone;
      logic [3:0] dsi;
      logic [2:0] point;
      logic [31:0] gain;
      logic [7:0][7:0] rb;
      logic [3:0] rl, rp;
      logic sra, srst, nvm;
      logic [31:0] src, trk, tkc, prd;
      logic [47:0] quo;
      logic [23:0] rem, den;
      logic [5:0] dc;
      logic db, dcal, dneg;
      logic [24:0] cv;
      logic [1:0] rng;
      logic ovr, und;
      logic [9:0] stp;
      lcd_res_s res;
   } lcd_state_s;
endpackage

/* tb/lcd_smp_src.sv */
// Sample source for the interpreter.
// Assumes the interpreter's clock; raw value comes from the bench.
`timescale 1ns/1ps
module lcd_smp_src
   import lcd_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [23:0] i_value,
   output lcd_smp_s o_smp
);
   // ****************
   // Sample pulses
   // ****************
   logic [3:0] cnt_q;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) cnt_q <= 4'h0;
      else cnt_q <= cnt_q + 4'h1;
   end
   // Sparse pulses; a busy divider drops some
   assign o_smp = {cnt_q == 4'hF, 1'b1, 1'b0, i_value};
endmodule

/* tb/lcd_chk_assertions.sv */
// Checker on the interpreter's bus and result ports.
// Bound into the interpreter from the bench top.
`timescale 1ns/1ps
module lcd_chk
   import lcd_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire lcd_res_s o_res,
   input wire logic o_nvm_save,
   input wire logic o_sys_reset
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   sequence s_acc;
      i_psel && !i_penable ##1 i_psel && i_penable;
   endsequence
   a_ready_now: assert property (o_pready == (i_psel && i_penable))
      else $error("pready");
   a_err_unmap: assert property (s_acc ##0 i_paddr > A_RES |-> o_pslverr)
      else $error("unmapped");
   a_err_ro: assert property (s_acc ##0 i_pwrite && i_paddr == A_TX |-> o_pslverr)
      else $error("ro write");
   a_save_pulse: assert property (o_nvm_save |=> !o_nvm_save)
      else $error("save pulse");
   a_reset_pulse: assert property (o_sys_reset |=> !o_sys_reset)
      else $error("reset pulse");
   a_range_max: assert property (o_res.range <= 2'h2)
      else $error("range");
   a_dp_max: assert property (o_res.point <= POINT_MAX)
      else $error("dp");
   a_over_zero: assert property (o_res.over |-> o_res.value == 24'h0)
      else $error("over");
endmodule

/* tb/tb.sv */
// Bench top: APB master sending text commands, reply monitor, verdict.
// Assumes zero wait state APB and one reply per command.
`timescale 1ns/1ps
module tb
   import lcd_pkg::*;
();
   logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, err, pready, pslverr, nvm, srst;
   logic [7:0] paddr = 8'h00, rnd = 8'h22;
   logic [31:0] pwdata = 32'h0, prdata, r;
   lcd_smp_s smp;
   lcd_res_s res;
   logic [7:0] q[$];
   int checks = 0, bad_count = 0, n_sr = 0, n_nvm = 0;
   always #4 clk = ~clk;
   lcd_smp_src part (.i_clock(clk), .i_rst_b(rst_b), .i_value({16'h0, rnd}), .o_smp(smp));
   lcd_cmd_interp #(.RST_CYC(200), .TRK_CYC(50), .DEV_CODE(16'h1234), .FW_CODE(16'h0567)) uut (
      .i_clock(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_smp(smp), .o_res(res), .o_nvm_save(nvm), .o_sys_reset(srst));
   // ****************
   // Helpers
   // ****************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      if (srst === 1'b1) n_sr <= n_sr + 1;
      if (nvm === 1'b1) n_nvm <= n_nvm + 1;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Each character read off TX consumes the oldest note
   always @(posedge clk) begin
      if (psel && pen && !pwr && paddr == A_TX && prdata[8] === 1'b1) begin
         if (q.size() == 0) chk("extra char", 32'h0, prdata);
         else chk("reply char", {24'h0, q.pop_front()}, {24'h0, prdata[7:0]});
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic cmd(input string c, input string e);
      foreach (c[i]) apb(1'b1, A_RX, {24'h0, c[i]});
      apb(1'b1, A_RX, {24'h0, CH_CR});
      foreach (e[i]) q.push_back(e[i]);
      r = 32'h0;
      for (int k = 0; k < 300 && r[1] !== 1'b1; k++) apb(1'b0, A_STAT, 32'h0);
      do apb(1'b0, A_TX, 32'h0); while (r[8] === 1'b1);
      chk("notes left", 32'h0, q.size());
      $display("test %s done", c);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      cmd("ID", "D:1234");
      cmd("IV", "V:0567");
      cmd("IS", "S:001000");
      cmd("CE", "E+00000");
      cmd("DP 2", "ERR");
      cmd("CE 1", "ERR");
      cmd("CE 0", "OK");
      cmd("DP 7", "ERR");
      cmd("DS 3", "ERR");
      cmd("DP 2", "OK");
      cmd("MR", "+0000000");
      cmd("CS", "OK");
      chk("saves", 32'h1, n_nvm);
      cmd("CE", "E+00001");
      cmd("DP 5", "ERR");
      apb(1'b0, A_RES, 32'h0);
      chk("dp", 32'h2, {29'h0, r[3:1]});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, A_TX, 32'h0);
      chk("ro write", 32'h1, {31'h0, err});
      cmd("CE 1", "OK");
      cmd("CM 1 0", "ERR");
      cmd("CM 2 500", "OK");
      cmd("CM 2", "+0000500");
      cmd("CI -5", "OK");
      cmd("CI", "-0000005");
      cmd("FD", "OK");
      chk("saves", 32'h2, n_nvm);
      cmd("CE", "E+00002");
      cmd("CM 2", "+0000000");
      cmd("SR", "OK");
      repeat (4) @(posedge clk);
      chk("resets", 32'h1, n_sr);
      summarize();
   end
endmodule
bind lcd_cmd_interp lcd_chk u_chk (.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .o_pready, .o_pslverr, .o_res, .o_nvm_save, .o_sys_reset);
